// file: hts_pkg.sv
// Package of the two-wire humidity sensor link: address, timing and states.
// Assumes a single 100 MHz system clock shared by both ends.
package hts_pkg;
	// ==========================================================
	// Addressing and bus timing
	localparam logic [6:0] HTS_TARGET_ADDR = 7'h44;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MEAS_TIME_US = 16900;
	localparam int MEAS_CYCLES = (MEAS_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int BIT_RATE_KHZ = 100;
	localparam int QUARTER_CYCLES = (1000000 / BIT_RATE_KHZ) / (4 * CLK_PERIOD_NS);
	localparam logic [1:0] STATUS_VALID = 2'h0;
	localparam logic [1:0] STATUS_STALE = 2'h1;
	localparam int RESULT_BYTES = 4;

	// ==========================================================
	// Target-side states
	typedef enum logic [2:0] {
		HTS_T_IDLE = 3'b000,
		HTS_T_ADDR = 3'b001,
		HTS_T_AACK = 3'b011,
		HTS_T_TX = 3'b010,
		HTS_T_MACK = 3'b110,
		HTS_T_RX = 3'b111,
		HTS_T_RACK = 3'b101,
		HTS_T_IGNORE = 3'b100
	} hts_tstate_e;

	// Controller-side states
	typedef enum logic [3:0] {
		HTS_C_IDLE = 4'b0000,
		HTS_C_START = 4'b0001,
		HTS_C_BIT = 4'b0011,
		HTS_C_ACK = 4'b0010,
		HTS_C_STOP = 4'b0110,
		HTS_C_DONE = 4'b0111
	} hts_cstate_e;
endpackage : hts_pkg

// file: hts_bus_if.sv
// Interface carrying the two open-drain wires between controller and sensor.
// Wire levels are resolved here as wired-AND with pull-ups.
`timescale 1ns/1ps
interface hts_bus_if;
	logic sclOeCtl;
	logic sdaOeCtl;
	logic sdaOeTgt;
	logic scl;
	logic sda;
	// Pull-ups: a line is low only while some party drives it
	assign scl = ~sclOeCtl;
	assign sda = ~(sdaOeCtl | sdaOeTgt);
	modport controller (output sclOeCtl, output sdaOeCtl, input scl, input sda);
	modport target (output sdaOeTgt, input scl, input sda);
endinterface : hts_bus_if

// file: hts_target.sv
// Sensor end: recognises its address, wakes a conversion on a write,
// returns four result bytes with a status pair on a read.
// Assumes bus wires synchronous to clk; the sensing core is modelled by sensorHum/sensorTemp.
`timescale 1ns/1ps

// Overview of operation
// - Target only; 100 and 400 kHz work
// - Controller frames transfers with START, STOP
// - Sample on rising clock; data stable while high
// - Answer only address 0x44
// - Direction bit: one read, zero write
// - Eight bits then acknowledge bit
// - Controller continues or stops after acknowledge
// - Sleep until a measurement request arrives
// - Only one controller on the bus
// - No lower clock rate limit
// - Request is address with write bit
// - Read returns humidity first, status on top
// - Status 00 fresh, 01 already fetched
// - Conversion takes 16.90 ms before update
module hts_target
	import hts_pkg::*;
#(
	parameter int MEAS_COUNT = MEAS_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	hts_bus_if.target bus,
	input wire logic [13:0] sensorHum,
	input wire logic [13:0] sensorTemp,
	output logic coreAwake,
	output logic [1:0] resultStatus
);
	// ==========================================================
	// Line edge and condition detection
	logic sclPrev, sdaPrev;
	logic sclRise, sclFall, startSeen, stopSeen;
	assign sclRise = bus.scl & ~sclPrev;
	// Edges only, no timeout, so any slow clock rate works
	assign sclFall = ~bus.scl & sclPrev;
	assign startSeen = bus.scl & sclPrev & sdaPrev & ~bus.sda;
	assign stopSeen = bus.scl & sclPrev & ~sdaPrev & bus.sda;

	// ==========================================================
	// Protocol state
	hts_tstate_e state, next_state;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shift, next_shift;
	logic [1:0] byteIdx, next_byteIdx;
	logic sdaOe, next_sdaOe;
	logic isRead, next_isRead;
	logic wakeReq, fetched;
	logic [31:0] result;
	logic [1:0] status;

	assign status = fetched ? STATUS_STALE : STATUS_VALID;

	function automatic logic [7:0] result_byte(input logic [31:0] r, input logic [1:0] i);
		result_byte = r[31 - 8 * i -: 8];
	endfunction : result_byte

	// Byte of the current index, for loading the next transmit byte
	logic [7:0] nextByte;
	assign nextByte = result_byte(result, byteIdx);

	always_comb begin
		next_state = state;
		next_bitCnt = bitCnt;
		next_shift = shift;
		next_byteIdx = byteIdx;
		next_sdaOe = sdaOe;
		next_isRead = isRead;
		wakeReq = 1'b0;
		if (startSeen) begin
			next_state = HTS_T_ADDR;
			next_bitCnt = 4'h0;
			next_sdaOe = 1'b0;
		end else if (stopSeen) begin
			next_state = HTS_T_IDLE;
			next_sdaOe = 1'b0;
		end else begin
			case (state)
				HTS_T_ADDR: begin
					if (sclRise) begin
						next_shift = {shift[6:0], bus.sda};
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == 4'h8) begin
						if (shift[7:1] == HTS_TARGET_ADDR) begin
							next_state = HTS_T_AACK;
							next_sdaOe = 1'b1;
							next_isRead = shift[0];
							next_byteIdx = 2'h0;
						end else begin
							next_state = HTS_T_IGNORE;
						end
					end
				end
				HTS_T_AACK: begin
					if (sclFall) begin
						next_bitCnt = 4'h0;
						if (isRead) begin
							next_state = HTS_T_TX;
							next_shift = result_byte(result, 2'h0);
							next_sdaOe = ~result[31];
						end else begin
							// A write wakes the core; trailing bytes are taken and ignored
							wakeReq = 1'b1;
							next_state = HTS_T_RX;
							next_sdaOe = 1'b0;
						end
					end
				end
				HTS_T_TX: begin
					if (sclFall) begin
						next_bitCnt = bitCnt + 4'h1;
						if (bitCnt == 4'h7) begin
							next_state = HTS_T_MACK;
							next_sdaOe = 1'b0;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_sdaOe = ~shift[6];
						end
					end
				end
				HTS_T_MACK: begin
					if (sclRise) begin
						// Controller NACK ends the read; it still has to send STOP
						next_state = bus.sda ? HTS_T_IGNORE : HTS_T_MACK;
						next_byteIdx = byteIdx + 2'h1;
						next_bitCnt = 4'h0;
					end else if (sclFall && bitCnt == 4'h0) begin
						next_state = HTS_T_TX;
						next_shift = nextByte;
						next_sdaOe = ~nextByte[7];
					end
				end
				HTS_T_RX: begin
					if (sclRise) begin
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == 4'h8) begin
						next_state = HTS_T_RACK;
						next_sdaOe = 1'b1;
					end
				end
				HTS_T_RACK: begin
					if (sclFall) begin
						next_state = HTS_T_RX;
						next_bitCnt = 4'h0;
						next_sdaOe = 1'b0;
					end
				end
				HTS_T_IDLE, HTS_T_IGNORE: begin
					next_sdaOe = 1'b0;
				end
				default: begin
					next_state = HTS_T_IDLE;
					next_sdaOe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			state <= HTS_T_IDLE;
			bitCnt <= 4'h0;
			shift <= 8'h00;
			byteIdx <= 2'h0;
			sdaOe <= 1'b0;
			isRead <= 1'b0;
		end else begin
			sclPrev <= bus.scl;
			sdaPrev <= bus.sda;
			state <= next_state;
			bitCnt <= next_bitCnt;
			shift <= next_shift;
			byteIdx <= next_byteIdx;
			sdaOe <= next_sdaOe;
			isRead <= next_isRead;
		end
	end

	assign bus.sdaOeTgt = sdaOe;

	// ==========================================================
	// Measurement core: asleep until requested
	logic [31:0] measCnt, next_measCnt;
	logic awake, next_awake;
	logic [31:0] next_result;
	logic next_fetched;
	logic fetchDone;
	// First byte leaving marks the data as fetched
	assign fetchDone = (state == HTS_T_AACK) && sclFall && isRead;

	always_comb begin
		next_measCnt = measCnt;
		next_awake = awake;
		next_result = result;
		next_fetched = fetched;
		if (fetchDone) begin
			next_fetched = 1'b1;
			next_result[31:30] = STATUS_STALE;
		end
		if (awake) begin
			if (measCnt == 32'(MEAS_COUNT - 1)) begin
				next_awake = 1'b0;
				next_result = {STATUS_VALID, sensorHum, sensorTemp, 2'h0};
				next_fetched = 1'b0;  // update beats a fetch in the same cycle
			end else begin
				next_measCnt = measCnt + 32'h1;
			end
		end else if (wakeReq) begin
			next_awake = 1'b1;
			next_measCnt = 32'h0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			measCnt <= 32'h0;
			awake <= 1'b0;
			// Before the first conversion the data reads stale
			result <= {STATUS_STALE, 30'h0};
			fetched <= 1'b1;
		end else begin
			measCnt <= next_measCnt;
			awake <= next_awake;
			result <= next_result;
			fetched <= next_fetched;
		end
	end

	assign coreAwake = awake;
	assign resultStatus = status;
endmodule : hts_target

// file: hts_controller.sv
// Controller end: issues a measurement request or a result fetch on command.
// Assumes it is the only controller on the bus and that targets do not stretch the clock.
`timescale 1ns/1ps
module hts_controller
	import hts_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	hts_bus_if.controller bus,
	input wire logic cmdValid,
	input wire logic cmdRead,
	input wire logic [2:0] readBytes,
	output logic cmdReady,
	output logic [31:0] readData,
	output logic acked,
	output logic done
);
	// ==========================================================
	// Quarter-bit timing
	hts_cstate_e state, next_state;
	logic [15:0] tick, next_tick;
	logic [1:0] phase, next_phase;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shift, next_shift;
	logic [2:0] byteCnt, next_byteCnt;
	logic [2:0] total, next_total;
	logic isRead, next_isRead, isAddr, next_isAddr;
	logic sclOe, next_sclOe, sdaOe, next_sdaOe;
	logic [31:0] data, next_data;
	logic ackOk, next_ackOk, doneP, next_doneP;
	logic step;
	assign step = (tick == 16'(QUARTER - 1));
	assign cmdReady = (state == HTS_C_IDLE);

	always_comb begin
		next_state = state;
		next_tick = step ? 16'h0 : tick + 16'h1;
		next_phase = phase;
		next_bitCnt = bitCnt;
		next_shift = shift;
		next_byteCnt = byteCnt;
		next_total = total;
		next_isRead = isRead;
		next_isAddr = isAddr;
		next_sclOe = sclOe;
		next_sdaOe = sdaOe;
		next_data = data;
		next_ackOk = ackOk;
		next_doneP = 1'b0;
		case (state)
			HTS_C_IDLE: begin
				next_tick = 16'h0;
				if (cmdValid) begin
					next_state = HTS_C_START;
					next_isRead = cmdRead;
					next_total = (readBytes == 3'h0 || readBytes > 3'(RESULT_BYTES)) ? 3'(RESULT_BYTES) : readBytes;
					next_shift = {HTS_TARGET_ADDR, cmdRead};
					next_phase = 2'h0;
				end
			end
			HTS_C_START: begin
				if (step) begin
					next_phase = phase + 2'h1;
					if (phase == 2'h0) next_sdaOe = 1'b1;
					if (phase == 2'h1) begin
						next_sclOe = 1'b1;
						next_state = HTS_C_BIT;
						next_bitCnt = 4'h0;
						next_isAddr = 1'b1;
						next_byteCnt = 3'h0;
						next_phase = 2'h0;
						next_data = 32'h0;
					end
				end
			end
			HTS_C_BIT, HTS_C_ACK: begin
				if (step) begin
					next_phase = phase + 2'h1;
					case (phase)
						2'h0: begin
							if (state == HTS_C_BIT) next_sdaOe = (isRead && !isAddr) ? 1'b0 : ~shift[7];
							else next_sdaOe = isRead && !isAddr && (byteCnt != total);
						end
						2'h1: next_sclOe = 1'b0;
						2'h2: begin
							if (state == HTS_C_BIT) next_shift = {shift[6:0], bus.sda};
							else if (isAddr) next_ackOk = ~bus.sda;
						end
						default: begin
							next_sclOe = 1'b1;
							if (state == HTS_C_BIT) begin
								next_bitCnt = bitCnt + 4'h1;
								if (bitCnt == 4'h7) begin
									next_state = HTS_C_ACK;
									if (isRead && !isAddr) begin
										next_data = {data[23:0], shift};
										next_byteCnt = byteCnt + 3'h1;
									end
								end
							end else begin
								next_bitCnt = 4'h0;
								next_isAddr = 1'b0;
								if (!ackOk || !isRead || (!isAddr && byteCnt == total)) begin
									next_state = HTS_C_STOP;
								end else begin
									next_state = HTS_C_BIT;
								end
							end
						end
					endcase
				end
			end
			HTS_C_STOP: begin
				if (step) begin
					next_phase = phase + 2'h1;
					if (phase == 2'h0) next_sdaOe = 1'b1;
					if (phase == 2'h1) next_sclOe = 1'b0;
					if (phase == 2'h2) begin
						next_sdaOe = 1'b0;
						next_state = HTS_C_DONE;
					end
				end
			end
			HTS_C_DONE: begin
				// Bus-free gap before the next command
				if (step) begin
					next_doneP = 1'b1;
					next_state = HTS_C_IDLE;
				end
			end
			default: next_state = HTS_C_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= HTS_C_IDLE;
			tick <= 16'h0;
			phase <= 2'h0;
			bitCnt <= 4'h0;
			shift <= 8'h00;
			byteCnt <= 3'h0;
			total <= 3'h0;
			isRead <= 1'b0;
			isAddr <= 1'b0;
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
			data <= 32'h0;
			ackOk <= 1'b0;
			doneP <= 1'b0;
		end else begin
			state <= next_state;
			tick <= next_tick;
			phase <= next_phase;
			bitCnt <= next_bitCnt;
			shift <= next_shift;
			byteCnt <= next_byteCnt;
			total <= next_total;
			isRead <= next_isRead;
			isAddr <= next_isAddr;
			sclOe <= next_sclOe;
			sdaOe <= next_sdaOe;
			data <= next_data;
			ackOk <= next_ackOk;
			doneP <= next_doneP;
		end
	end

	assign bus.sclOeCtl = sclOe;
	assign bus.sdaOeCtl = sdaOe;
	assign readData = data;
	assign acked = ackOk;
	assign done = doneP;
endmodule : hts_controller

// file: hts_link_properties.sv
// Checker of the two-wire link between controller and sensor.
// Assumes it watches the first link only, with the shortened bit timing.
`timescale 1ns/1ps
module hts_link_properties #(
	parameter int QUARTER = 5
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclOeCtl,
	input wire logic sdaOeCtl,
	input wire logic sdaOeTgt,
	input wire logic scl,
	input wire logic sda
);
	// ==========================================================
	// Frame tracking
	// Longest fetch plus START, STOP and gap
	localparam int FRAME_MAX = 49 * 4 * QUARTER;
	logic sclPrev;
	logic sdaPrev;
	logic next_sclPrev;
	logic next_sdaPrev;
	logic [3:0] bitCount;
	logic [3:0] next_bitCount;
	logic startCond;
	logic stopCond;
	logic sclRise;
	assign startCond = scl & sclPrev & sdaPrev & ~sda;
	assign stopCond = scl & sclPrev & ~sdaPrev & sda;
	assign sclRise = scl & ~sclPrev;

	// Count of clock rises since START; 4'hF means idle
	always_comb begin
		next_sclPrev = scl;
		next_sdaPrev = sda;
		next_bitCount = bitCount;
		if (startCond) begin
			next_bitCount = 4'h0;
		end else if (stopCond) begin
			next_bitCount = 4'hF;
		end else if (sclRise && bitCount != 4'hF) begin
			next_bitCount = bitCount + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			bitCount <= 4'hF;
		end else begin
			sclPrev <= next_sclPrev;
			sdaPrev <= next_sdaPrev;
			bitCount <= next_bitCount;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_tgt_moves_low: assert property ($changed(sdaOeTgt) |-> !scl)
		else $error("target changed data while clock high");
	a_addr_ack_low: assert property (sclRise && bitCount == 4'h8 |-> !sda)
		else $error("own address not acknowledged");
	a_addr_tgt_quiet: assert property (bitCount < 4'h8 |-> !sdaOeTgt)
		else $error("target drove data during address");
	a_addr_no_frame: assert property (bitCount < 4'h9 |-> !stopCond && !startCond)
		else $error("start or stop inside address byte");
	// Target must stay off the data line for four cycles after a frame has closed
	a_stop_tgt_idle: assert property (stopCond |-> ##1 (!sdaOeTgt)[*4])
		else $error("target drove data after stop");
	a_start_by_ctl: assert property (startCond |-> sdaOeCtl && !sdaOeTgt)
		else $error("start not made by controller");
	a_clock_high_width: assert property (sclRise |-> scl[*4])
		else $error("clock high phase too short");
	a_frame_ends: assert property (startCond |-> ##[1:FRAME_MAX] stopCond)
		else $error("frame not closed by stop");
endmodule : hts_link_properties

// file: humidity_sensor_i2c_slave_tb.sv
// Testbench: controller and sensor on one link, a second sensor on a hand-driven link.
// Assumes shortened conversion and bit timing parameters.
`timescale 1ns/1ps
module humidity_sensor_i2c_slave_tb
	import hts_pkg::*;
;
	localparam int MEAS = 200;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cmdValid = 1'b0;
	logic cmdRead = 1'b0;
	logic [2:0] readBytes = 3'h0;
	logic [13:0] hum = 14'h2A5C;
	logic [13:0] temp = 14'h1B37;
	logic cmdReady, acked, done, awake, awake2, ack, ack2;
	logic [31:0] readData;
	logic [1:0] status, status2;
	logic fgnWatch = 1'b0;
	logic fgnDrive = 1'b0;
	int miscompares = 0;
	int nCompared = 0;
	int awakeCycles = 0;
	hts_bus_if bus ();
	hts_bus_if bus2 ();
	hts_controller #(.QUARTER(5)) i_hts_controller (.clk(clk), .reset(reset), .bus(bus), .cmdValid(cmdValid),
		.cmdRead(cmdRead), .readBytes(readBytes), .cmdReady(cmdReady), .readData(readData), .acked(acked), .done(done));
	hts_target #(.MEAS_COUNT(MEAS)) i_hts_target (.clk(clk), .reset(reset), .bus(bus), .sensorHum(hum),
		.sensorTemp(temp), .coreAwake(awake), .resultStatus(status));
	hts_target #(.MEAS_COUNT(MEAS)) i_hts_target_2 (.clk(clk), .reset(reset), .bus(bus2), .sensorHum(hum),
		.sensorTemp(temp), .coreAwake(awake2), .resultStatus(status2));
	hts_link_properties #(.QUARTER(5)) i_hts_link_properties (.clk(clk), .reset(reset), .sclOeCtl(bus.sclOeCtl),
		.sdaOeCtl(bus.sdaOeCtl), .sdaOeTgt(bus.sdaOeTgt), .scl(bus.scl), .sda(bus.sda));

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (awake === 1'b1) awakeCycles++;
		if (fgnWatch && bus2.sdaOeTgt !== 1'b0) fgnDrive = 1'b1;
	end

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task closeOut;
		$display("compared %0d mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : closeOut

	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// Command on the first link, bounded waits on ready and done
	task run(input logic rd, input logic [2:0] n);
		int i;
		for (i = 0; i < 20 && cmdReady !== 1'b1; i++) step(1);
		if (cmdReady !== 1'b1) begin
			miscompares++;
			closeOut();
		end
		cmdValid = 1'b1;
		cmdRead = rd;
		readBytes = n;
		step(1);
		cmdValid = 1'b0;
		check("busy while running", 32'h0, 32'(cmdReady));
		for (i = 0; i < 3000 && done !== 1'b1; i++) step(1);
		if (done !== 1'b1) begin
			miscompares++;
			closeOut();
		end
	endtask : run

	// Hand-driven controller for the second link, four cycles a phase
	task send_bit(input logic b, output logic s);
		bus2.sdaOeCtl = ~b;
		step(4);
		bus2.sclOeCtl = 1'b0;
		step(4);
		s = bus2.sda;
		bus2.sclOeCtl = 1'b1;
	endtask : send_bit

	task send_byte(input logic [7:0] v, output logic a);
		int i;
		logic s;
		for (i = 7; i >= 0; i--) send_bit(v[i], s);
		send_bit(1'b1, a);
	endtask : send_byte

	task send_frame(input logic [7:0] a0, input logic second, output logic a, output logic a2);
		// The bench alone drives clock, start and stop on the second link
		bus2.sdaOeCtl = 1'b1;
		step(4);
		bus2.sclOeCtl = 1'b1;
		send_byte(a0, a);
		a2 = 1'b1;
		if (second) send_byte(8'h00, a2);
		bus2.sdaOeCtl = 1'b1;
		step(4);
		bus2.sclOeCtl = 1'b0;
		step(4);
		bus2.sdaOeCtl = 1'b0;
		step(8);
	endtask : send_frame

	// ==========================================================
	// Main sequence
	initial begin
		int i;
		bus2.sclOeCtl = 1'b0;
		bus2.sdaOeCtl = 1'b0;
		step(2);
		reset = 1'b0;
		check("status at reset", 32'(STATUS_STALE), 32'(status));
		check("awake at reset", 32'h0, 32'(awake));
		check("ready at reset", 32'h1, 32'(cmdReady));
		run(1'b1, 3'h4);
		check("fetch acked", 32'h1, 32'(acked));
		check("early status", 32'(STATUS_STALE), 32'(readData[31:30]));
		check("no wake on fetch", 32'h0, 32'(awake));
		run(1'b0, 3'h0);
		check("request acked", 32'h1, 32'(acked));
		check("awake after request", 32'h1, 32'(awake));
		for (i = 0; i < 400 && awake === 1'b1; i++) step(1);
		if (awake !== 1'b0) begin
			miscompares++;
			closeOut();
		end
		check("conversion length", 32'(MEAS), 32'(awakeCycles));
		check("status fresh", 32'(STATUS_VALID), 32'(status));
		run(1'b1, 3'h4);
		check("four bytes", {STATUS_VALID, hum, temp, 2'h0}, readData);
		check("status fetched", 32'(STATUS_STALE), 32'(status));
		run(1'b1, 3'h2);
		check("two bytes", 32'({STATUS_STALE, hum}), 32'(readData[15:0]));
		fgnWatch = 1'b1;
		send_frame({7'h45, 1'b0}, 1'b1, ack, ack2);
		fgnWatch = 1'b0;
		check("foreign address nack", 32'h1, 32'(ack));
		check("foreign data nack", 32'h1, 32'(ack2));
		check("foreign data line", 32'h0, 32'(fgnDrive));
		check("no wake on foreign", 32'h0, 32'(awake2));
		check("foreign status", 32'(STATUS_STALE), 32'(status2));
		send_frame({HTS_TARGET_ADDR, 1'b0}, 1'b1, ack, ack2);
		check("own address ack", 32'h0, 32'(ack));
		check("discarded byte ack", 32'h0, 32'(ack2));
		check("wake on request", 32'h1, 32'(awake2));
		closeOut();
	end
endmodule : humidity_sensor_i2c_slave_tb
